// ### logic/ctm_pkg.sv
// Package for the compact 10-bit timer: register map, fields, modes.
// Assumes byte-wide register port and a 50 MHz system clock.
package ctm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte index on the register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] CTM_OFF_CNT_LO  = 3'h0;
  localparam logic [2:0] CTM_OFF_CNT_HI  = 3'h1;
  localparam logic [2:0] CTM_OFF_CMPA_LO = 3'h2;
  localparam logic [2:0] CTM_OFF_CMPA_HI = 3'h3;
  localparam logic [2:0] CTM_OFF_CTRL0   = 3'h4;
  localparam logic [2:0] CTM_OFF_CTRL1   = 3'h5;
  localparam logic [2:0] CTM_OFF_FLAGS   = 3'h6;

  // ----------------------------------------------------------------
  // Widths, reset values, field positions
  // ----------------------------------------------------------------
  localparam int          CTM_CNT_W     = 10;
  localparam logic [7:0]  CTM_BYTE_RST  = 8'h00;
  localparam logic [9:0]  CTM_CNT_ZERO  = 10'h000;
  localparam logic [9:0]  CTM_CNT_ONE   = 10'h001;
  localparam logic [9:0]  CTM_CNT_MAX   = 10'h3FF;
  localparam logic [2:0]  CTM_PER_ZERO  = 3'h0;
  localparam int          CTM_PER_LSB   = 7;
  localparam int          CTM_C0_PAUSE  = 7;
  localparam int          CTM_C0_CKS_HI = 6;
  localparam int          CTM_C0_CKS_LO = 4;
  localparam int          CTM_C0_ON     = 3;
  localparam int          CTM_C0_PER_HI = 2;
  localparam int          CTM_C1_MODE_HI = 7;
  localparam int          CTM_C1_MODE_LO = 6;
  localparam int          CTM_C1_IO_HI  = 5;
  localparam int          CTM_C1_IO_LO  = 4;
  localparam int          CTM_C1_OC     = 3;
  localparam int          CTM_C1_POL    = 2;
  localparam int          CTM_C1_DPX    = 1;
  localparam int          CTM_C1_CCLR   = 0;
  localparam int          CTM_FLG_A     = 0;
  localparam int          CTM_FLG_P     = 1;

  // ----------------------------------------------------------------
  // Prescaler divide ratios
  // ----------------------------------------------------------------
  localparam logic [5:0]  CTM_DIV4_MASK  = 6'h03;
  localparam logic [5:0]  CTM_DIV16_MASK = 6'h0F;
  localparam logic [5:0]  CTM_DIV64_MASK = 6'h3F;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CTM_MODE_CMP  = 2'h0,
    CTM_MODE_UNDF = 2'h1,
    CTM_MODE_PWM  = 2'h2,
    CTM_MODE_TMR  = 2'h3
  } ctm_mode_t;

  typedef enum logic [2:0] {
    CTM_CK_SYS4  = 3'h0,
    CTM_CK_SYS   = 3'h1,
    CTM_CK_H16   = 3'h2,
    CTM_CK_H64   = 3'h3,
    CTM_CK_SUB0  = 3'h4,
    CTM_CK_SUB1  = 3'h5,
    CTM_CK_EXTR  = 3'h6,
    CTM_CK_EXTF  = 3'h7
  } ctm_clk_sel_t;

  localparam logic [1:0] CTM_IO_NONE = 2'h0;
  localparam logic [1:0] CTM_IO_LOW  = 2'h1;
  localparam logic [1:0] CTM_IO_HIGH = 2'h2;
  localparam logic [1:0] CTM_IO_TOG  = 2'h3;

endpackage : ctm_pkg

// ### logic/ctm_pin_sync.sv
// Three-stage synchroniser and edge detector for the external clock pin.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none

module ctm_pin_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pin side
  input  wire logic pin_in,
  // Edge pulses
  output logic      rise_out,
  output logic      fall_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Capture chain; a change counts once it reaches stage two while stage three still holds the old level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge pulses where stages two and three differ
  assign rise_out = s2_q & ~s3_q;
  assign fall_out = ~s2_q & s3_q;

endmodule : ctm_pin_sync

`default_nettype wire

// ### logic/ctm_prescaler.sv
// Tick generator for the internal clock choices of the timer.
// Assumes the high clock equals the system clock and sub ticks come in.
`timescale 1ns/1ps
`default_nettype none

module ctm_prescaler (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Run control
  input  wire logic run_in,
  // Tick outputs
  output logic      div4_out,
  output logic      div16_out,
  output logic      div64_out
);

  logic [5:0] div_q;

  // Free divider, held while the unit is powered down
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_q <= 6'h00;
    end else if (run_in) begin
      div_q <= div_q + 6'h01;
    end
  end

  // One-cycle ticks at each ratio
  assign div4_out  = run_in && ((div_q & ctm_pkg::CTM_DIV4_MASK) == ctm_pkg::CTM_DIV4_MASK);
  assign div16_out = run_in && ((div_q & ctm_pkg::CTM_DIV16_MASK) == ctm_pkg::CTM_DIV16_MASK);
  assign div64_out = run_in && (div_q == ctm_pkg::CTM_DIV64_MASK);

endmodule : ctm_prescaler

`default_nettype wire

// ### logic/ctm_timer.sv
// Compact 10-bit timer with period and compare comparators, top module.
// Assumes a byte register port, one cycle read latency, sub clock ticks in.
`timescale 1ns/1ps
`default_nettype none

module ctm_timer (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Clock sources
  input  wire logic       sub_tick_in,
  input  wire logic       ext_clock_pin_in,
  // Waveform pin and flags
  output logic            wave_output_pin_out,
  output logic            wave_output_en_out,
  output logic            compare_a_flag_out,
  output logic            period_match_flag_out
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] counter_q;
  logic [9:0] compare_a_value_q;
  logic [7:0] low_buf_q;
  logic       compare_a_flag_q;
  logic       period_match_flag_q;
  logic       pin_q;
  logic       on_prev_q;
  logic [7:0] rdata_q;

  // Field views
  logic                  pause_ctrl;
  logic                  timer_on_off;
  logic [2:0]            period_compare_value;
  ctm_pkg::ctm_clk_sel_t clock_select;
  ctm_pkg::ctm_mode_t    operating_mode_sel;
  logic [1:0]            pin_function_sel;
  logic                  output_initial_level;
  logic                  output_polarity;
  logic                  duty_period_swap;
  logic                  clear_source_sel;

  assign pause_ctrl           = ctrl0_q[ctm_pkg::CTM_C0_PAUSE];
  assign clock_select         = ctm_pkg::ctm_clk_sel_t'(
                                  ctrl0_q[ctm_pkg::CTM_C0_CKS_HI:ctm_pkg::CTM_C0_CKS_LO]);
  assign timer_on_off         = ctrl0_q[ctm_pkg::CTM_C0_ON];
  assign period_compare_value = ctrl0_q[ctm_pkg::CTM_C0_PER_HI:0];
  assign operating_mode_sel   = ctm_pkg::ctm_mode_t'(
                                  ctrl1_q[ctm_pkg::CTM_C1_MODE_HI:ctm_pkg::CTM_C1_MODE_LO]);
  assign pin_function_sel     = ctrl1_q[ctm_pkg::CTM_C1_IO_HI:ctm_pkg::CTM_C1_IO_LO];
  assign output_initial_level = ctrl1_q[ctm_pkg::CTM_C1_OC];
  assign output_polarity      = ctrl1_q[ctm_pkg::CTM_C1_POL];
  assign duty_period_swap     = ctrl1_q[ctm_pkg::CTM_C1_DPX];
  assign clear_source_sel     = ctrl1_q[ctm_pkg::CTM_C1_CCLR];

  // Register port decode helper
  function automatic logic hit(input logic strobe, input logic [2:0] a,
                               input logic [2:0] off);
    hit = strobe && (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Tick sources
  // ----------------------------------------------------------------
  logic tick_div4;
  logic tick_div16;
  logic tick_div64;
  logic ext_rise;
  logic ext_fall;
  logic cnt_tick;

  ctm_prescaler u_presc (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .run_in    (timer_on_off),
    .div4_out  (tick_div4),
    .div16_out (tick_div16),
    .div64_out (tick_div64)
  );

  ctm_pin_sync u_ext (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pin_in   (ext_clock_pin_in),
    .rise_out (ext_rise),
    .fall_out (ext_fall)
  );

  // Counter tick from the selected source
  always_comb begin
    case (clock_select)
      ctm_pkg::CTM_CK_SYS4: cnt_tick = tick_div4;
      ctm_pkg::CTM_CK_SYS:  cnt_tick = 1'b1;
      ctm_pkg::CTM_CK_H16:  cnt_tick = tick_div16;
      ctm_pkg::CTM_CK_H64:  cnt_tick = tick_div64;
      ctm_pkg::CTM_CK_SUB0: cnt_tick = sub_tick_in;
      ctm_pkg::CTM_CK_SUB1: cnt_tick = sub_tick_in;
      ctm_pkg::CTM_CK_EXTR: cnt_tick = ext_rise;
      ctm_pkg::CTM_CK_EXTF: cnt_tick = ext_fall;
      default:              cnt_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Comparators and clear logic
  // ----------------------------------------------------------------
  logic       run;
  logic       on_rise;
  logic       a_match;
  logic       p_match;
  logic       at_max;
  logic       per_zero;
  logic       is_pwm;
  logic       clear_now;
  logic       set_a;
  logic       set_p;

  // No step or match in the switch-on cycle, the counter is being zeroed
  assign run      = timer_on_off && !pause_ctrl && cnt_tick && !on_rise;
  assign on_rise  = timer_on_off && !on_prev_q;
  assign per_zero = (period_compare_value == ctm_pkg::CTM_PER_ZERO);
  assign at_max   = (counter_q == ctm_pkg::CTM_CNT_MAX);
  assign is_pwm   = (operating_mode_sel == ctm_pkg::CTM_MODE_PWM);

  // Match seen as the counter steps onto the compare value
  assign a_match  = run && (compare_a_value_q != ctm_pkg::CTM_CNT_ZERO)
                    && ((counter_q + ctm_pkg::CTM_CNT_ONE) == compare_a_value_q);
  assign p_match  = run && (per_zero ? at_max
                    : (((counter_q + ctm_pkg::CTM_CNT_ONE) >> ctm_pkg::CTM_PER_LSB)
                       == {7'h00, period_compare_value}));

  // Clear source: PWM takes period role from swap bit, else clear select
  always_comb begin
    if (is_pwm) begin
      clear_now = duty_period_swap ? (a_match || (run && at_max))
                                   : p_match;
    end else if (clear_source_sel) begin
      clear_now = a_match || (run && at_max);
    end else begin
      clear_now = p_match;
    end
  end

  // Flag events; period flag suppressed with compare clear outside PWM
  assign set_a = a_match;
  assign set_p = p_match && (is_pwm || !clear_source_sel);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Edge tracker for the on/off bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= timer_on_off;
    end
  end

  // Up counter: zero on switch-on, hold when off or paused
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      counter_q <= ctm_pkg::CTM_CNT_ZERO;
    end else if (on_rise) begin
      counter_q <= ctm_pkg::CTM_CNT_ZERO;
    end else if (run) begin
      if (clear_now) begin
        counter_q <= ctm_pkg::CTM_CNT_ZERO;
      end else begin
        counter_q <= counter_q + ctm_pkg::CTM_CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  logic [9:0] duty_len;
  logic       pwm_active;
  logic       pin_level;

  // Duty length from the role the swap bit gives
  assign duty_len   = duty_period_swap
                      ? (per_zero ? ctm_pkg::CTM_CNT_MAX
                         : {period_compare_value, 7'h00})
                      : compare_a_value_q;
  assign pwm_active = (counter_q < duty_len) || (duty_period_swap && per_zero);

  // Compare-mode pin state, set by switch-on and moved only by compare flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_q <= 1'b0;
    end else if (operating_mode_sel == ctm_pkg::CTM_MODE_CMP) begin
      if (on_rise) begin
        pin_q <= output_initial_level;
      end else if (set_a) begin
        case (pin_function_sel)
          ctm_pkg::CTM_IO_NONE: pin_q <= pin_q;
          ctm_pkg::CTM_IO_LOW:  pin_q <= 1'b0;
          ctm_pkg::CTM_IO_HIGH: pin_q <= 1'b1;
          ctm_pkg::CTM_IO_TOG:  pin_q <= ~pin_q;
          default:              pin_q <= pin_q;
        endcase
      end
    end
  end

  // Pin level before polarity, by mode
  always_comb begin
    case (operating_mode_sel)
      ctm_pkg::CTM_MODE_CMP: pin_level = pin_q;
      ctm_pkg::CTM_MODE_PWM: begin
        case (pin_function_sel)
          ctm_pkg::CTM_IO_NONE: pin_level = ~output_initial_level;
          ctm_pkg::CTM_IO_LOW:  pin_level = output_initial_level;
          ctm_pkg::CTM_IO_HIGH: pin_level = pwm_active ? output_initial_level
                                                       : ~output_initial_level;
          default:              pin_level = 1'b0;
        endcase
      end
      default:               pin_level = 1'b0;
    endcase
  end

  // Registered pin with polarity, disabled in timer and underflow modes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wave_output_pin_out <= 1'b0;
      wave_output_en_out  <= 1'b0;
    end else if (operating_mode_sel == ctm_pkg::CTM_MODE_TMR ||
                 operating_mode_sel == ctm_pkg::CTM_MODE_UNDF) begin
      wave_output_pin_out <= 1'b0;
      wave_output_en_out  <= 1'b0;
    end else begin
      wave_output_pin_out <= pin_level ^ output_polarity;
      wave_output_en_out  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control registers; mode changes expected only while off
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl0_q <= ctm_pkg::CTM_BYTE_RST;
      ctrl1_q <= ctm_pkg::CTM_BYTE_RST;
    end else begin
      if (hit(wr_in, addr_in, ctm_pkg::CTM_OFF_CTRL0)) begin
        ctrl0_q <= wdata_in;
      end
      if (hit(wr_in, addr_in, ctm_pkg::CTM_OFF_CTRL1)) begin
        ctrl1_q <= wdata_in;
      end
    end
  end

  // Low-byte buffer: filled by low write or high-byte read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      low_buf_q <= ctm_pkg::CTM_BYTE_RST;
    end else if (hit(wr_in, addr_in, ctm_pkg::CTM_OFF_CMPA_LO)) begin
      low_buf_q <= wdata_in;
    end else if (hit(rd_in, addr_in, ctm_pkg::CTM_OFF_CNT_HI)) begin
      low_buf_q <= counter_q[7:0];
    end else if (hit(rd_in, addr_in, ctm_pkg::CTM_OFF_CMPA_HI)) begin
      low_buf_q <= compare_a_value_q[7:0];
    end
  end

  // Compare value loads whole on the high-byte write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      compare_a_value_q <= ctm_pkg::CTM_CNT_ZERO;
    end else if (hit(wr_in, addr_in, ctm_pkg::CTM_OFF_CMPA_HI)) begin
      compare_a_value_q <= {wdata_in[1:0], low_buf_q};
    end
  end

  // Sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      compare_a_flag_q    <= 1'b0;
      period_match_flag_q <= 1'b0;
    end else begin
      if (set_a) begin
        compare_a_flag_q <= 1'b1;
      end else if (hit(wr_in, addr_in, ctm_pkg::CTM_OFF_FLAGS) &&
                   wdata_in[ctm_pkg::CTM_FLG_A]) begin
        compare_a_flag_q <= 1'b0;
      end
      if (set_p) begin
        period_match_flag_q <= 1'b1;
      end else if (hit(wr_in, addr_in, ctm_pkg::CTM_OFF_FLAGS) &&
                   wdata_in[ctm_pkg::CTM_FLG_P]) begin
        period_match_flag_q <= 1'b0;
      end
    end
  end

  assign compare_a_flag_out    = compare_a_flag_q;
  assign period_match_flag_out = period_match_flag_q;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= ctm_pkg::CTM_BYTE_RST;
    end else if (rd_in) begin
      case (addr_in)
        ctm_pkg::CTM_OFF_CNT_LO:  rdata_q <= low_buf_q;
        ctm_pkg::CTM_OFF_CNT_HI:  rdata_q <= {6'h00, counter_q[9:8]};
        ctm_pkg::CTM_OFF_CMPA_LO: rdata_q <= low_buf_q;
        ctm_pkg::CTM_OFF_CMPA_HI: rdata_q <= {6'h00, compare_a_value_q[9:8]};
        ctm_pkg::CTM_OFF_CTRL0:   rdata_q <= ctrl0_q;
        ctm_pkg::CTM_OFF_CTRL1:   rdata_q <= ctrl1_q;
        ctm_pkg::CTM_OFF_FLAGS:   rdata_q <= {6'h00, period_match_flag_q,
                                              compare_a_flag_q};
        default:                  rdata_q <= ctm_pkg::CTM_BYTE_RST;
      endcase
    end else begin
      rdata_q <= ctm_pkg::CTM_BYTE_RST;
    end
  end

  assign rdata_out = rdata_q;

endmodule : ctm_timer

`default_nettype wire

// ### verification/ctm_chk.sv
// Checker: port-level assertions for the compact timer.
// Assumes it is bound to ctm_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ctm_chk (
  // Clock, reset and register port
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  // Pin and flags
  input wire logic       wave_output_pin_out,
  input wire logic       wave_output_en_out,
  input wire logic       compare_a_flag_out,
  input wire logic       period_match_flag_out
);
  logic cclr_q;

  // Clear source copied from control writes
  always_ff @(posedge clk_in) begin
    if (rst_in) cclr_q <= 1'b0;
    else if (wr_in && addr_in == 3'h5) cclr_q <= wdata_in[0] && wdata_in[7:6] != 2'h2;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  cnt_hi_zero_a: assert property ($past(rd_in) && $past(addr_in) == 3'h1
    |-> rdata_out[7:2] == 6'h00) else $error("counter high byte upper bits set");
  cmp_hi_zero_a: assert property ($past(rd_in) && $past(addr_in) == 3'h3
    |-> rdata_out[7:2] == 6'h00) else $error("compare high byte upper bits set");
  flag_a_hold_a: assert property ($past(compare_a_flag_out) &&
    !($past(wr_in) && $past(addr_in) == 3'h6 && $past(wdata_in[0]))
    |-> compare_a_flag_out) else $error("compare flag dropped");
  flag_p_hold_a: assert property ($past(period_match_flag_out) &&
    !($past(wr_in) && $past(addr_in) == 3'h6 && $past(wdata_in[1]))
    |-> period_match_flag_out) else $error("period flag dropped");
  no_pflag_a: assert property (cclr_q && $past(cclr_q)
    |-> !$rose(period_match_flag_out)) else $error("period flag with clear select one");
  tmr_no_pin_a: assert property (wr_in && addr_in == 3'h5 && wdata_in[7:6] == 2'h3
    |-> ##2 !wave_output_en_out) else $error("pin driven in timer mode");
  cmp_pin_en_a: assert property (wr_in && addr_in == 3'h5 && wdata_in[7:6] == 2'h0
    |-> ##2 wave_output_en_out) else $error("pin not driven in compare mode");
  pin_idle_lo_a: assert property (!wave_output_en_out
    |-> !wave_output_pin_out) else $error("undriven pin not low");
endmodule : ctm_chk

bind ctm_timer ctm_chk u_chk (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .wave_output_pin_out, .wave_output_en_out, .compare_a_flag_out,
  .period_match_flag_out);
`default_nettype wire

// ### verification/ctm_ext_src.sv
// Partner: square wave on the external clock pin.
// Assumes the pin runs free, unrelated in phase to clk_in.
`timescale 1ns/1ps
`default_nettype none

module ctm_ext_src #(
  parameter int HALF_NS = 100
) (
  // Pin output
  output logic pin_out
);
  // Free-running wave, offset from the system clock edges
  initial begin
    pin_out = 1'b0;
    #37;
    forever #(HALF_NS) pin_out = ~pin_out;
  end
endmodule : ctm_ext_src
`default_nettype wire

// ### verification/tb_top.sv
// Testbench: register port driver, read notes checked through a queue.
// Assumes ctm_timer, ctm_chk and ctm_ext_src are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk_in, rst_in, wr_in, rd_in, sub_tick_in, pin, en, fa, fp, ext_pin, rd_d1;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, lo, hi, m;
  logic [7:0] exp_q[$], msk_q[$];
  int         fail_count, cmp_count, n, h, sub_cnt;
  int         div_t[8] = '{4, 1, 16, 64, 8, 8, 10, 10};
  logic [7:0] pw_c[5] = '{8'hA8, 8'h88, 8'h98, 8'hAA, 8'hAC};
  int         pw_h[5] = '{64, 0, 256, 256, 192};

  ctm_timer u_dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .sub_tick_in, .ext_clock_pin_in(ext_pin), .wave_output_pin_out(pin),
    .wave_output_en_out(en), .compare_a_flag_out(fa), .period_match_flag_out(fp));
  ctm_ext_src u_src (.pin_out(ext_pin));

  // System clock, 20 ns
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Sub clock tick every eighth cycle
  always @(posedge clk_in) begin
    sub_cnt <= sub_cnt + 1;
    sub_tick_in <= (sub_cnt % 8 == 7);
  end

  // Oldest read note against the data of the cycle after the strobe
  always @(posedge clk_in) begin
    if (rd_d1 === 1'b1) begin
      m = msk_q.pop_front();
      chk((rdata_out & m) === exp_q.pop_front(), "read data");
    end
    rd_d1 <= rd_in;
  end

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(k);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd

  task automatic setc(input logic [9:0] v);
    wr(3'h2, v[7:0]);
    wr(3'h3, {6'h00, v[9:8]});
  endtask : setc

  // Off, configure, clear flags, on
  task automatic start(input logic [7:0] c1, input logic [7:0] c0);
    wr(3'h4, 8'h00);
    wr(3'h5, c1);
    wr(3'h6, 8'h03);
    wr(3'h4, c0);
  endtask : start

  task automatic wait_fa(input int lim);
    n = 0;
    while (fa !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("[FAIL] %0t compare flag wait ran out", $time);
      finish_test();
    end
  endtask : wait_fa

  // Main sequence
  initial begin
    rst_in = 1'b1;
    {wr_in, rd_in} = 2'h0;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    {fail_count, cmp_count, h} = '0;
    n = $urandom(32'h8a83);
    tick(16);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00, 8'hFF);
    $display("test reset_values done");
    lo = 8'($urandom);
    hi = 8'($urandom);
    setc({hi[1:0], lo});
    rd(3'h3, {6'h00, hi[1:0]}, 8'hFF);
    rd(3'h2, lo, 8'hFF);
    $display("test buffer done");
    setc(10'h028);
    for (int i = 0; i < 8; i++) begin
      lo[0] = 1'($urandom);
      hi[0] = (i[1:0] == 2'h0) ? lo[0] : (i[1:0] == 2'h3) ? ~lo[0] : i[1];
      start({2'h0, i[1:0], lo[0], i[2], 2'h1}, 8'h18);
      tick(3);
      chk(pin === (lo[0] ^ i[2]), "initial level");
      wait_fa(80);
      tick(2);
      chk(pin === (hi[0] ^ i[2]), "match level");
    end
    $display("test compare_pin done");
    setc(10'h000);
    start(8'h31, 8'h19);
    tick(1100);
    chk(fa === 1'b0 && fp === 1'b0 && pin === 1'b0, "overflow case");
    rd(3'h1, 8'h00, 8'hFC);
    $display("test overflow done");
    setc(10'h040);
    start(8'h30, 8'h1A);
    tick(150);
    chk(fa === 1'b1 && fp === 1'b0, "flags at 150");
    tick(150);
    chk(fp === 1'b1, "period flag");
    rd(3'h1, 8'h00, 8'hFF);
    start(8'h30, 8'h18);
    tick(900);
    chk(fp === 1'b0, "period zero early");
    tick(200);
    chk(fp === 1'b1, "period zero overflow");
    $display("test period done");
    setc(10'h032);
    start(8'h31, 8'h18);
    tick(10);
    wr(3'h4, 8'h98);
    tick(100);
    chk(fa === 1'b0, "paused");
    wr(3'h4, 8'h18);
    wait_fa(45);
    $display("test pause done");
    setc(10'h008);
    for (int s = 0; s < 8; s++) begin
      start(8'hF1, {1'b0, s[2:0], 4'h8});
      tick(div_t[s] * 4);
      chk(fa === 1'b0 && en === 1'b0, "clock early");
      wait_fa(div_t[s] * 12);
    end
    $display("test clock_select done");
    setc(10'h020);
    for (int k = 0; k < 5; k++) begin
      start(pw_c[k], 8'h19);
      tick(140);
      h = 0;
      repeat (256) begin
        tick(1);
        h += int'(pin);
      end
      chk(h == pw_h[k], "pwm duty");
    end
    $display("test pwm done");
    tick(4);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
